// [logic/apc_pkg.sv]
package apc_pkg;

  // Byte and shift widths
  localparam int          BYTE_W            = 8;
  localparam int          BIT_CNT_W         = 4;
  localparam logic [3:0]  BITS_AFTER_LOAD   = 4'h7;

  // Shift clock: system clock cycles per shift period
  localparam int          CLK_PERIOD_NS     = 40;
  localparam int          SHIFT_PERIOD_NS   = 160;
  localparam int          SHIFT_DIV         = SHIFT_PERIOD_NS / CLK_PERIOD_NS;

  // Busy time bounds, in shift periods
  localparam logic [1:0]  BUSY_MIN_PERIODS  = 2'h2;
  localparam logic [3:0]  BUSY_MAX_PERIODS  = 4'h9;

  // Reset values
  localparam logic [7:0]  BYTE_RESET        = 8'h00;

  // Pin bundle, sampled as one word by the synchroniser
  typedef struct packed {
    logic       select_low_active_n;
    logic       select_high_active;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       init_all_high;
    logic [7:0] data;
  } apc_pins_type;

  // Serial stream towards the configuration logic
  typedef struct packed {
    logic valid;
    logic bit_value;
  } apc_serial_type;

endpackage

// [logic/apc_sync.sv]
// Two-stage synchroniser for a word of asynchronous pins
module apc_sync #(
  parameter int WIDTH = 1
) (
  // Clocking
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // First stage is read by the second stage only
  logic [WIDTH-1:0] meta;

  // Both stages frozen with the clock enable
  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [logic/apc_loader.sv]
module apc_loader
  import apc_pkg::*;
#(
  parameter int DIV = SHIFT_DIV
) (
  // Clocking
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Processor port pins
  input  wire logic                 select_low_active_n,
  input  wire logic                 select_high_active,
  input  wire logic                 write_strobe_n,
  input  wire logic                 read_strobe_n,
  input  wire logic [BYTE_W-1:0]    data_in,
  // Daisy-chain init level
  input  wire logic                 init_all_high,
  // Status to processor
  output logic                      ready_busy,
  // Serial configuration stream
  output logic                      config_shift_clock,
  output logic                      serial_data,
  output logic                      serial_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  apc_pins_type raw_pins;     // Pins gathered into one word
  apc_pins_type pins;         // Pins after two flip-flops

  assign raw_pins = '{select_low_active_n, select_high_active,
                      write_strobe_n, read_strobe_n, init_all_high, data_in};

  apc_sync #(
    .WIDTH ($bits(apc_pins_type))
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .async_in (raw_pins),
    .sync_out (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and capture

  logic              write_now;    // Decoded write cycle
  logic              write_q;      // Write seen last cycle
  logic [BYTE_W-1:0] data_last;    // Bus value seen during the write
  logic              enable;       // Port live once init is High
  logic              write_end;    // Terminating edge of a write
  logic              accept;       // Byte goes into the input register
  logic              input_full;   // First level holds a byte

  // All four qualifiers must agree, or the cycle is no write
  assign write_now = !pins.select_low_active_n && !pins.write_strobe_n
                  && pins.read_strobe_n && pins.select_high_active;
  assign enable    = pins.init_all_high;
  assign write_end = write_q && !write_now;
  // A byte landing on a full input register is dropped; host broke pacing
  assign accept    = enable && write_end && !input_full;

  // Track the decoded write and the data it carried
  always_ff @(posedge clk) begin
    if (rst) begin
      write_q   <= 1'b0;
      data_last <= BYTE_RESET;
    end else if (ce) begin
      write_q <= write_now;
      // Data at the end edge may already be gone, so keep the last good value
      if (write_now) begin
        data_last <= pins.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift clock generator

  logic [$clog2(DIV+1)-1:0] div_cnt;   // Phase of the shift clock
  logic                     tick;      // One cycle per shift period

  assign tick = ce && (div_cnt == ($bits(div_cnt))'(DIV - 1));

  // Free-running divider; its phase decides when a new byte starts
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      div_cnt            <= '0;
      config_shift_clock <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
      // High for the first half of each period
      config_shift_clock <= (div_cnt < ($bits(div_cnt))'(DIV / 2 - 1)) || tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-level converter

  logic [BYTE_W-1:0]    input_reg;   // First level
  logic [BYTE_W-1:0]    shift_reg;   // Second level
  logic [BIT_CNT_W-1:0] bits_left;   // Bits still to send
  logic                 load;        // Move first level into second

  // Reload only when the previous byte is fully out, on a period edge
  assign load = tick && input_full && (bits_left == '0);

  // Input register: set by accept, cleared by the reload
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      input_reg  <= BYTE_RESET;
      input_full <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        input_reg  <= data_last;
        input_full <= 1'b1;
      end else if (load) begin
        input_full <= 1'b0;
      end
    end
  end

  // Shifter: first bit leaves with the load, the rest one per period
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      shift_reg    <= BYTE_RESET;
      bits_left    <= '0;
      serial_data  <= 1'b0;
      serial_valid <= 1'b0;
    end else if (ce) begin
      serial_valid <= 1'b0;
      if (load) begin
        serial_data  <= input_reg[BYTE_W-1];
        shift_reg    <= {input_reg[BYTE_W-2:0], 1'b0};
        bits_left    <= BITS_AFTER_LOAD;
        serial_valid <= 1'b1;
      end else if (tick && bits_left != '0) begin
        serial_data  <= shift_reg[BYTE_W-1];
        shift_reg    <= {shift_reg[BYTE_W-2:0], 1'b0};
        bits_left    <= bits_left - 1'b1;
        serial_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready/busy

  // The first tick after accept only closes a partial period, so one extra
  // tick is counted; that guarantees two whole shift periods of busy
  localparam logic [1:0] BUSY_DONE = BUSY_MIN_PERIODS + 2'h1;

  logic [1:0] busy_periods;   // Ticks since the last accept
  logic       next_ready;     // Ready for the next cycle

  // Count ticks after accept; saturate once the minimum busy time is served
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      busy_periods <= BUSY_DONE;
    end else if (ce) begin
      if (accept) begin
        busy_periods <= 2'h0;
      end else if (tick && busy_periods != BUSY_DONE) begin
        busy_periods <= busy_periods + 2'h1;
      end
    end
  end

  // Ready needs room in the first level and the minimum time served
  assign next_ready = enable && !accept && !input_full
                   && (busy_periods == BUSY_DONE);

  // Register the status pin; low while the port is not yet live
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_busy <= 1'b0;
    end else if (ce) begin
      ready_busy <= next_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int FAST_MAX = 3 * DIV + 2;   // Busy bound for an empty converter

  logic [3:0] busy_ticks;   // Periods seen while busy, for the upper bound

  // Frozen with the clock enable like the rest of the state
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ticks <= 4'h0;
    end else if (ce) begin
      if (ready_busy) begin
        busy_ticks <= 4'h0;
      end else if (tick && busy_ticks != 4'hF) begin
        busy_ticks <= busy_ticks + 4'h1;
      end
    end
  end

  write_decode_a: assert property (@(posedge clk) disable iff (rst)
    accept && ce |-> !write_now && $past(!pins.select_low_active_n && !pins.write_strobe_n
                                        && pins.read_strobe_n && pins.select_high_active))
    else $error("byte accepted without a decoded write");

  busy_follows_a: assert property (@(posedge clk) disable iff (rst)
    accept && ce |=> !ready_busy)
    else $error("ready stayed high after accept");

  busy_min_a: assert property (@(posedge clk) disable iff (rst)
    $rose(ready_busy) |-> busy_periods == BUSY_DONE && !input_full)
    else $error("busy ended before the minimum periods");

  busy_max_a: assert property (@(posedge clk) disable iff (rst)
    enable |-> busy_ticks <= BUSY_MAX_PERIODS + 4'h1)
    else $error("busy lasted beyond the maximum periods");

  room_when_ready_a: assert property (@(posedge clk) disable iff (rst)
    ready_busy |-> !input_full)
    else $error("ready while the input register is full");

  empty_fast_a: assert property (@(posedge clk) disable iff (rst)
    accept && bits_left == '0 && ce |-> ##[1:FAST_MAX] (ready_busy || !ce || !enable))
    else $error("busy too long for an empty converter");

  capture_data_a: assert property (@(posedge clk) disable iff (rst)
    accept && ce |=> input_full && input_reg == $past(data_last))
    else $error("captured byte differs from the written byte");

  load_aligned_a: assert property (@(posedge clk) disable iff (rst)
    $fell(input_full) && enable |-> $past(tick) && $past(bits_left) == '0)
    else $error("reload off the period edge or mid-byte");

  bit_count_a: assert property (@(posedge clk) disable iff (rst)
    load |=> bits_left == BITS_AFTER_LOAD && serial_valid
          && serial_data == $past(input_reg[BYTE_W-1]))
    else $error("shifter reload wrong");

endmodule

// [dv/apc_host_model.sv]
module apc_host_model
  import apc_pkg::*;
#(
  parameter int DIV = SHIFT_DIV
) (
  // Clocking
  input  wire logic    clk,
  // Device side
  input  wire logic    ready_busy,
  input  wire logic    init_all_high,
  // Pins toward the device
  output apc_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle: deselected, both strobes high
  initial pins = {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00};

  // One write cycle; odd selects let a scenario try a decode that must be ignored
  task automatic write_cycle(input logic sl_n, sh, rs_n, input logic [7:0] value, output bit late);
    int n;
    int good;
    n = 0;
    good = 0;
    // Wait up to 1000 cycles while any chained device still holds init low
    while (init_all_high !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    #1 pins = {sl_n, sh, 1'b0, rs_n, 1'b1, value};
    // Strobe ends only after ready stood high a full shift period
    while (good <= DIV && n < 3000) begin
      @(posedge clk);
      n++;
      good = (ready_busy === 1'b1) ? good + 1 : 0;
    end
    late = (n >= 3000);
    // Data not held past the strobe edge, so a late sample shows garbage
    #1 pins = {sl_n, sh, 1'b1, rs_n, 1'b1, ~value};
    repeat (3) @(posedge clk);
    #1 pins = {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, ~value};
  endtask
endmodule

// [dv/apc_loader_bench.sv]
module apc_loader_bench;
  import apc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int DIV = 4;

  logic         clk;
  logic         rst;
  logic         ce;
  logic         init_all_high;
  logic         ready_busy;
  logic         config_shift_clock;
  logic         serial_data;
  logic         serial_valid;
  apc_pins_type pins;
  int           error_cnt;
  int           n_compared;
  int           busy_run;
  int           busy_q[$];
  logic [7:0]   byte_q[$];
  logic [7:0]   acc;
  int           nbits;
  int           gap;

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  apc_loader #(.DIV(DIV)) apc_loader_inst (
    .clk(clk), .rst(rst), .ce(ce),
    .select_low_active_n(pins.select_low_active_n), .select_high_active(pins.select_high_active),
    .write_strobe_n(pins.write_strobe_n), .read_strobe_n(pins.read_strobe_n), .data_in(pins.data),
    .init_all_high(init_all_high), .ready_busy(ready_busy), .config_shift_clock(config_shift_clock),
    .serial_data(serial_data), .serial_valid(serial_valid));

  apc_host_model #(.DIV(DIV)) apc_host_model_inst (
    .clk(clk), .ready_busy(ready_busy), .init_all_high(init_all_high), .pins(pins));

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    n_compared++;
    if (seen !== expected) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%0h expected=%0h", $time, seen, expected);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitors: busy run lengths, serial bytes MSB first, bit spacing
  always @(posedge clk) begin
    gap++;
    if (rst || ready_busy !== 1'b0) begin
      if (busy_run > 0 && !rst) busy_q.push_back(busy_run);
      busy_run = 0;
    end else
      busy_run++;
    if (serial_valid === 1'b1) begin
      check(config_shift_clock, 1'b1);
      if (nbits > 0) check(gap, DIV);
      acc = {acc[6:0], serial_data};
      gap = 0;
      nbits++;
      if (nbits == 8) begin
        byte_q.push_back(acc);
        nbits = 0;
      end
    end
  end

  task automatic clear_mon();
    busy_q.delete();
    byte_q.delete();
    nbits = 0;
  endtask

  // Write with chosen selects: {low select, high select, read strobe}
  task automatic wr(input logic [2:0] sel, input logic [7:0] v);
    bit late;
    apc_host_model_inst.write_cycle(sel[2], sel[1], sel[0], v, late);
    check(late, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_burst();
    logic [7:0] v[4];
    v = '{8'hA5, 8'h3C, 8'h81, 8'h00};
    clear_mon();
    // Back-to-back: later bytes queue behind a shifting byte
    foreach (v[i]) wr(3'h3, v[i]);
    // Last byte may wait behind a full byte in the shifter
    repeat (20 * DIV) @(posedge clk);
    check(byte_q.size(), 4);
    foreach (v[i]) check(byte_q[i], v[i]);
    foreach (busy_q[i]) check(busy_q[i] >= 2 * DIV && busy_q[i] <= 9 * DIV + 1, 1);
    check(busy_q[0] <= 3 * DIV, 1);
    check(busy_q[1] > busy_q[0], 1);
    $display("test_burst done");
  endtask

  task automatic test_decode();
    logic [2:0] bad[3];
    bad = '{3'h7, 3'h1, 3'h2};
    clear_mon();
    // Each combination breaks exactly one qualifier of a write
    foreach (bad[i]) wr(bad[i], 8'h5A);
    repeat (12 * DIV) @(posedge clk);
    check(byte_q.size() + busy_q.size(), 0);
    $display("test_decode done");
  endtask

  task automatic test_init();
    #1 init_all_high = 1'b0;
    repeat (6) @(posedge clk);
    check(ready_busy, 1'b0);
    check(config_shift_clock, 1'b0);
    #1 init_all_high = 1'b1;
    repeat (8) @(posedge clk);
    check(ready_busy, 1'b1);
    clear_mon();
    wr(3'h3, 8'hC3);
    repeat (12 * DIV) @(posedge clk);
    check(byte_q.size(), 1);
    check(byte_q[0], 8'hC3);
    $display("test_init done");
  endtask

  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog: the scenarios need well under 2000 cycles
  initial begin
    #(40 * 20000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    init_all_high = 1'b1;
    error_cnt = 0;
    n_compared = 0;
    busy_run = 0;
    nbits = 0;
    gap = 0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge clk);
    check(ready_busy, 1'b1);
    test_burst();
    test_decode();
    test_init();
    print_verdict();
  end
endmodule
